// file: led_port_regs.svh
/*
  Constants of the two-wire slave port: slave identity, byte framing,
  reset values and the timing counts of the port.
  Assumes it is included by bare name after the package, on a 25 MHz clock.
*/
`ifndef LED_PORT_REGS_SVH
`define LED_PORT_REGS_SVH

// ----------------------------------------------------------------------
// Slave identity and framing
// ----------------------------------------------------------------------
`define SLAVE_ID_UPPER      5'h0c
`define BITS_PER_BYTE       4'h8
`define POINTER_RESET       8'h00
`define SYNC_WIDTH          6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLOCK_HZ            25000000
`define EXT_CLK_MIN_HZ      4000
`define EXT_CLK_TIMEOUT_CYC (`CLOCK_HZ / `EXT_CLK_MIN_HZ)

`endif

// file: led_port_pkg.sv
/*
  Types shared by the slave port modules: state encoding and the packed
  state records of the port and of the condition detector.
  Assumes nothing of its surroundings.
*/
package led_port_pkg;

  // ----------------------------------------------------------------------
  // Transfer state, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_IDLE     = 10'h001,
    ST_ADDR     = 10'h002,
    ST_ADDR_ACK = 10'h004,
    ST_PTR      = 10'h008,
    ST_PTR_ACK  = 10'h010,
    ST_WDATA    = 10'h020,
    ST_WACK     = 10'h040,
    ST_RDATA    = 10'h080,
    ST_RACK     = 10'h100,
    ST_IGNORE   = 10'h200
  } port_state_e;

  // ----------------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------------
  typedef struct packed {
    port_state_e state;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic [7:0]  txShift;
    logic [7:0]  ptr;
    logic        rw;
    logic        masterAck;
    logic        sdaDrive;
    logic        busy;
    logic        wrStrobe;
    logic        rdStrobe;
    logic [7:0]  wrData;
    logic        startupHold;
    logic        extPrev;
    logic [12:0] extTimer;
    logic        extPresent;
    logic        oscOff;
  } port_state_s;

  typedef struct packed {
    logic sclPrev;
    logic sdaPrev;
  } cond_state_s;

endpackage

// file: bus_events_if.sv
/*
  Carrier of the decoded line events from the condition detector to the
  transfer logic of the slave port.
  Assumes one clock domain: every signal is valid on the port clock.
*/
`timescale 1ns/10ps
interface bus_events_if;
  logic sclHigh;
  logic sdaLevel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  modport detector (
    output sclHigh,
    output sdaLevel,
    output sclRise,
    output sclFall,
    output startSeen,
    output stopSeen
  );

  modport port (
    input sclHigh,
    input sdaLevel,
    input sclRise,
    input sclFall,
    input startSeen,
    input stopSeen
  );
endinterface

// file: pin_sync.sv
/*
  Two-stage synchroniser for a group of pins from outside the clock domain.
  Assumes inputs may change at any time relative to clock.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinsAsync,
  output logic      [WIDTH-1:0] pinsSync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_s;

  sync_state_s q;
  sync_state_s d;

  // The first stage feeds only the second, to let metastability settle.
  always_comb begin
    d        = q;
    d.stage1 = pinsAsync;
    d.stage2 = q.stage1;
  end

  // Synchronous reset clears both stages to zero.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pinsSync = q.stage2;

endmodule

// file: bus_condition_detect.sv
/*
  Finds clock edges and start and stop conditions on the synchronised
  two-wire lines and hands them on as one-cycle events.
  Assumes both lines already passed a two-stage synchroniser.
*/
`timescale 1ns/10ps
module bus_condition_detect (
  input  wire logic    clock,
  input  wire logic    rst_n,
  input  wire logic    sclSync,
  input  wire logic    sdaSync,
  bus_events_if.detector ev
);

  led_port_pkg::cond_state_s q;
  led_port_pkg::cond_state_s d;

  // ----------------------------------------------------------------------
  // Previous samples
  // ----------------------------------------------------------------------
  always_comb begin
    d         = q;
    d.sclPrev = sclSync;
    d.sdaPrev = sdaSync;
  end

  // Reset to high, the idle level, so no false start or stop follows reset.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------------
  // Data moving while the clock stays high is a control code, never data.
  assign ev.sclHigh   = sclSync;
  assign ev.sdaLevel  = sdaSync;
  assign ev.sclRise   = sclSync & ~q.sclPrev;                            // RULE23
  assign ev.sclFall   = ~sclSync & q.sclPrev;                            // RULE23
  assign ev.startSeen = sclSync & q.sclPrev & q.sdaPrev & ~sdaSync;      // RULE4
  assign ev.stopSeen  = sclSync & q.sclPrev & ~q.sdaPrev & sdaSync;      // RULE4

endmodule

// file: led_serial_port.sv
/*
  Two-wire serial slave port of a four-channel LED driver. It decodes the
  bus, matches the pin-selected slave identity, keeps an auto-incrementing
  register pointer and issues register write and read strobes.
  Assumes the register file answers regRdData combinationally for regAddr,
  and that the pad combines sdaOut and sdaOe as an open-drain driver.
  Bus clock phases must last four clocks or more: the lines reach the
  decoder two clocks after the pins.
  // Overview of operation
  // RULE1 - Sample data on clock high, change on low.
  // RULE2 - Data change on clock high aborts transfer.
  // RULE3 - Bytes are eight bits, MSB first, then acknowledge.
  // RULE4 - Start: data falls; stop: data rises; clock high.
  // RULE5 - Only master makes start and stop.
  // RULE6 - Repeated start begins a new address phase.
  // RULE7 - Master clocks a ninth pulse per byte.
  // RULE8 - Transmitter releases data in acknowledge slot.
  // RULE9 - Receiver holds data low through acknowledge high.
  // RULE10 - Master leaves last read byte unacknowledged.
  // RULE11 - Address is fixed upper bits plus select pins.
  // RULE12 - Bit after address: one read, zero write.
  // RULE13 - Acknowledge only own address, else stay released.
  // RULE14 - Write: pointer, then data bytes, each acknowledged.
  // RULE15 - Pointer increments after each written data byte.
  // RULE16 - Read: pointer write, repeated start, read address.
  // RULE17 - Track busy bus; ignore traffic for others.
  // RULE18 - Thermal fault holds startup until it clears.
  // RULE19 - Power save plus slow clock stops oscillator.
  // RULE20 - Acknowledged read byte advances pointer, sends next.
  // RULE21 - Read ends on not-acknowledge then stop.
  // RULE22 - Program memory bytes are read one at a time.
  // RULE23 - Synchronise lines, find edges before decoding.
*/
`timescale 1ns/10ps
`include "led_port_regs.svh"
module led_serial_port #(
  parameter int unsigned EXT_CLK_TIMEOUT = `EXT_CLK_TIMEOUT_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       slave_id_select_low,
  input  wire logic       slave_id_select_high,
  input  wire logic       external_slow_clock_in,
  input  wire logic       thermalShutdown,
  input  wire logic       powerSaveActive,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  output logic            regWrStrobe,
  input  wire logic [7:0] regRdData,
  output logic            regRdStrobe,
  output logic            busBusy,
  output logic            startupHold,
  output logic            extClockPresent,
  output logic            oscillatorOff
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [`SYNC_WIDTH-1:0] pinsSync;
  logic                   sclSync;
  logic                   sdaSync;
  logic                   selLowSync;
  logic                   selHighSync;
  logic                   extClkSync;
  logic                   faultSync;
  logic [6:0]             ownId;

  // Every outside level but powerSaveActive passes two flops before any decoding looks at it.
  pin_sync #(
    .WIDTH (`SYNC_WIDTH)
  ) u_pin_sync (
    .clock     (clock),
    .rst_n     (rst_n),
    .pinsAsync ({thermalShutdown, external_slow_clock_in, slave_id_select_high,
                 slave_id_select_low, sdaIn, sclIn}),
    .pinsSync  (pinsSync)
  );                                                                     // RULE23

  // Unpack the synchronised group.
  assign sclSync     = pinsSync[0];
  assign sdaSync     = pinsSync[1];
  assign selLowSync  = pinsSync[2];
  assign selHighSync = pinsSync[3];
  assign extClkSync  = pinsSync[4];
  assign faultSync   = pinsSync[5];

  // The select pins form the two lowest identity bits.
  // They are live pins, so keep them still during a transfer.
  assign ownId = {`SLAVE_ID_UPPER, selHighSync, selLowSync};             // RULE11

  // ----------------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------------
  bus_events_if ev ();

  bus_condition_detect u_cond (
    .clock   (clock),
    .rst_n   (rst_n),
    .sclSync (sclSync),
    .sdaSync (sdaSync),
    .ev      (ev.detector)
  );

  // ----------------------------------------------------------------------
  // Port state
  // ----------------------------------------------------------------------
  led_port_pkg::port_state_s q;
  led_port_pkg::port_state_s d;

  // One process computes every next value of the port.
  always_comb begin
    d          = q;
    d.wrStrobe = 1'b0;
    d.rdStrobe = 1'b0;

    // Slow clock watchdog: any edge within the timeout means present.
    // A stuck line in either level times out and reads as absent.
    d.extPrev = extClkSync;
    if (extClkSync != q.extPrev) begin
      d.extTimer   = '0;
      d.extPresent = 1'b1;
    end else if (q.extTimer != 13'(EXT_CLK_TIMEOUT - 1)) begin
      d.extTimer = q.extTimer + 13'h0001;
    end else begin
      d.extPresent = 1'b0;
    end
    d.oscOff = powerSaveActive & q.extPresent;                           // RULE19

    d.startupHold = faultSync;                                           // RULE18

    // Fault and bus conditions outrank any byte in flight.
    if (faultSync) begin
      // A hot die drops out of any transfer and stays in startup.
      d.state    = led_port_pkg::ST_IDLE;                                // RULE18
      d.sdaDrive = 1'b0;
      d.busy     = 1'b0;
      d.bitCnt   = '0;
    end else if (ev.startSeen) begin
      // A start mid-byte aborts it; a repeated start needs no stop first.
      d.state    = led_port_pkg::ST_ADDR;                                // RULE6
      d.sdaDrive = 1'b0;                                                 // RULE2
      d.busy     = 1'b1;                                                 // RULE17
      d.bitCnt   = '0;
    end else if (ev.stopSeen) begin
      d.state    = led_port_pkg::ST_IDLE;                                // RULE2
      d.sdaDrive = 1'b0;
      d.busy     = 1'b0;                                                 // RULE17
      d.bitCnt   = '0;
    end else begin
      case (q.state)
        led_port_pkg::ST_ADDR,
        led_port_pkg::ST_PTR,
        led_port_pkg::ST_WDATA: begin
          // Receive: shift in on the rising clock, most significant first.
          if (ev.sclRise && q.bitCnt != `BITS_PER_BYTE) begin
            d.shift  = {q.shift[6:0], ev.sdaLevel};                      // RULE1
            d.bitCnt = q.bitCnt + 4'h1;                                  // RULE3
          end else if (ev.sclFall && q.bitCnt == `BITS_PER_BYTE) begin
            d.bitCnt = '0;
            if (q.state == led_port_pkg::ST_ADDR) begin
              if (q.shift[7:1] == ownId) begin
                d.rw       = q.shift[0];                                 // RULE12
                d.sdaDrive = 1'b1;                                       // RULE13
                d.state    = led_port_pkg::ST_ADDR_ACK;
              end else begin
                d.state = led_port_pkg::ST_IGNORE;                       // RULE17
              end
            end else if (q.state == led_port_pkg::ST_PTR) begin
              d.ptr      = q.shift;                                      // RULE14
              d.sdaDrive = 1'b1;                                         // RULE9
              d.state    = led_port_pkg::ST_PTR_ACK;
            end else begin
              d.wrData   = q.shift;
              d.wrStrobe = 1'b1;                                         // RULE14
              d.sdaDrive = 1'b1;                                         // RULE9
              d.state    = led_port_pkg::ST_WACK;
            end
          end
        end

        led_port_pkg::ST_ADDR_ACK: begin
          // The ninth falling edge ends our acknowledge.
          if (ev.sclFall) begin                                          // RULE7
            if (q.rw) begin
              d.txShift  = {regRdData[6:0], 1'b0};                       // RULE16
              d.sdaDrive = ~regRdData[7];
              d.rdStrobe = 1'b1;
              d.state    = led_port_pkg::ST_RDATA;
            end else begin
              d.sdaDrive = 1'b0;
              d.state    = led_port_pkg::ST_PTR;
            end
          end
        end

        // Pointer acknowledge ends at the ninth fall.
        led_port_pkg::ST_PTR_ACK: begin
          if (ev.sclFall) begin
            d.sdaDrive = 1'b0;
            d.state    = led_port_pkg::ST_WDATA;
          end
        end

        led_port_pkg::ST_WACK: begin
          // Advance only once the acknowledge is over, ready for the next byte.
          if (ev.sclFall) begin
            d.sdaDrive = 1'b0;
            d.ptr      = q.ptr + 8'h01;                                  // RULE15
            d.state    = led_port_pkg::ST_WDATA;
          end
        end

        led_port_pkg::ST_RDATA: begin
          // Transmit: change data only after the clock falls.
          if (ev.sclRise && q.bitCnt != `BITS_PER_BYTE) begin
            d.bitCnt = q.bitCnt + 4'h1;                                  // RULE3
          end else if (ev.sclFall) begin
            if (q.bitCnt == `BITS_PER_BYTE) begin
              d.sdaDrive = 1'b0;                                         // RULE8
              d.bitCnt   = '0;
              d.state    = led_port_pkg::ST_RACK;
            end else begin
              d.sdaDrive = ~q.txShift[7];                                // RULE1
              d.txShift  = {q.txShift[6:0], 1'b0};
            end
          end
        end

        led_port_pkg::ST_RACK: begin
          // A low line at the ninth rise asks for the next register.
          // Program memory gives no sequential data, so masters read it
          // one byte per transfer; the port itself does not police that.
          if (ev.sclRise) begin
            d.masterAck = ~ev.sdaLevel;
            if (ev.sdaLevel) begin
              d.state = led_port_pkg::ST_IGNORE;                         // RULE21
            end else begin
              d.ptr = q.ptr + 8'h01;                                     // RULE20
            end
          end else if (ev.sclFall && q.masterAck) begin
            d.masterAck = 1'b0;
            d.txShift   = {regRdData[6:0], 1'b0};                        // RULE20
            d.sdaDrive  = ~regRdData[7];
            d.rdStrobe  = 1'b1;
            d.state     = led_port_pkg::ST_RDATA;
          end
        end

        led_port_pkg::ST_IGNORE: begin
          // Released until the next start or stop.
          d.sdaDrive = 1'b0;                                             // RULE13
        end

        // Nothing concerns the port until a start.
        led_port_pkg::ST_IDLE: begin
          d.sdaDrive = 1'b0;
        end

        // A stray code falls back to idle.
        default: begin
          d.state    = led_port_pkg::ST_IDLE;
          d.sdaDrive = 1'b0;
        end
      endcase
    end
  end

  // Synchronous reset leaves the port idle with the line released.
  // The pointer restarts so a first read is defined.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q       <= '0;
      q.state <= led_port_pkg::ST_IDLE;
      q.ptr   <= `POINTER_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Strobes and data leave straight from flops.
  // Open drain: the port only ever pulls low, never drives start or stop.
  assign sdaOut          = 1'b0;                                         // RULE5
  assign sdaOe           = q.sdaDrive;
  assign regAddr         = q.ptr;
  assign regWrData       = q.wrData;
  assign regWrStrobe     = q.wrStrobe;
  assign regRdStrobe     = q.rdStrobe;
  assign busBusy         = q.busy;
  assign startupHold     = q.startupHold;
  assign extClockPresent = q.extPresent;
  assign oscillatorOff   = q.oscOff;

endmodule

// file: led_serial_port_sva.sv
/*
  Checker of the slave port: bus answers, strobes, busy and fault states.
  Assumes it is bound into led_serial_port and sees only its ports.
*/
`timescale 1ns/10ps
module led_serial_port_sva #(
  parameter int unsigned EXT_CLK_TIMEOUT = 64
) (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOe,
  input wire logic       thermalShutdown,
  input wire logic       powerSaveActive,
  input wire logic [7:0] regAddr,
  input wire logic       regWrStrobe,
  input wire logic [7:0] regRdData,
  input wire logic       regRdStrobe,
  input wire logic       busBusy,
  input wire logic       startupHold,
  input wire logic       extClockPresent,
  input wire logic       oscillatorOff
);
  logic [7:0] wrAddrQ;

  // Pointer of the last write, kept so the step after its acknowledge can be checked.
  always_ff @(posedge clock) begin
    if (regWrStrobe) begin
      wrAddrQ <= regAddr;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_fault; startupHold |-> !sdaOe && !regWrStrobe && !regRdStrobe; endproperty
  a_fault: assert property (p_fault) else $error("port answered under fault");
  property p_fault_in; $rose(thermalShutdown) |-> ##[1:4] startupHold; endproperty
  a_fault_in: assert property (p_fault_in) else $error("fault not taken");
  property p_ptr_step; regWrStrobe |-> ##[8:24] (regAddr == wrAddrQ + 8'h01); endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");
  property p_wr_pulse; regWrStrobe |-> busBusy ##1 !regWrStrobe; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe malformed");
  property p_one_strobe; !(regWrStrobe && regRdStrobe); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes high");
  property p_msb; regRdStrobe |-> (sdaOe == !regRdData[7]); endproperty
  a_msb: assert property (p_msb) else $error("first read bit wrong");
  property p_start; $rose(busBusy) |-> sclIn && !sdaIn; endproperty
  a_start: assert property (p_start) else $error("busy without start");
  property p_stop; $fell(busBusy) |-> sclIn && sdaIn; endproperty
  a_stop: assert property (p_stop) else $error("idle without stop");
  property p_low_change; $changed(sdaOe) |-> !sclIn; endproperty
  a_low_change: assert property (p_low_change) else $error("data moved on clock high");
  property p_osc; powerSaveActive && extClockPresent |=> oscillatorOff; endproperty
  a_osc: assert property (p_osc) else $error("oscillator kept on");

  c_write: cover property (regWrStrobe);
  c_read: cover property (regRdStrobe);
  c_fault: cover property (startupHold);
  c_osc: cover property (oscillatorOff);
endmodule

bind led_serial_port led_serial_port_sva #(.EXT_CLK_TIMEOUT(EXT_CLK_TIMEOUT)) i_sva (
  .clock(clock), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
  .thermalShutdown(thermalShutdown), .powerSaveActive(powerSaveActive),
  .regAddr(regAddr), .regWrStrobe(regWrStrobe), .regRdData(regRdData),
  .regRdStrobe(regRdStrobe), .busBusy(busBusy), .startupHold(startupHold),
  .extClockPresent(extClockPresent), .oscillatorOff(oscillatorOff));

// file: bus_master_model.sv
/*
  Behavioural two-wire bus master that clocks bytes and conditions.
  Assumes the data line has a pull-up and is resolved by the bench.
*/
`timescale 1ns/10ps
module bus_master_model (
  output logic      sclOut,
  output logic      sdaPull,
  input  wire logic sdaLine
);
  // Idle bus: clock high, data released to the pull-up.
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end

  // One bit: data moves only in the low phase, sampled mid high phase.
  // Phases are 160 ns, so the port answers within the low phase.
  task automatic bitX(input logic b, output logic s);
    sdaPull = !b;
    #80 sclOut = 1'b1;
    #80 s = sdaLine;
    #80 sclOut = 1'b0;
    #80;
  endtask

  // Eight bits MSB first, then the ninth pulse with lastBit on the line.
  task automatic byteX(input logic [7:0] d, input logic lastBit, output logic [7:0] r,
                       output logic ackLine);
    for (int i = 7; i >= 0; i--) begin
      bitX(d[i], r[i]);
    end
    bitX(lastBit, ackLine);
  endtask

  // Start or repeated start; the clock stays high a while after data falls.
  task automatic startCond();
    sdaPull = 1'b0;
    #80 sclOut = 1'b1;
    #80 sdaPull = 1'b1;
    #160 sclOut = 1'b0;
    #80;
  endtask

  task automatic stopCond();
    sdaPull = 1'b1;
    #80 sclOut = 1'b1;
    #80 sdaPull = 1'b0;
    #240;
  endtask
endmodule

// file: tb_top.sv
/*
  Self-checking bench of the slave port with a register array behind it.
  Assumes the port samples the bus asynchronously to its 25 MHz clock.
*/
`timescale 1ns/10ps
module tb_top;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       sclIn;
  logic       sdaPull;
  logic       sdaWire;
  logic       sdaOut;
  logic       sdaOe;
  logic [1:0] sel = 2'h0;
  logic       slowClk = 1'b0;
  logic       thermal = 1'b0;
  logic       powerSave = 1'b0;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrStrobe;
  logic       regRdStrobe;
  logic       busBusy;
  logic       startupHold;
  logic       extPresent;
  logic       oscOff;
  logic [7:0] mem [256];
  int         n_errors = 0;
  int         checks = 0;
  int         cycles = 0;

  always #20 clock = ~clock;
  // Open-drain wire: low when either party pulls, else the pull-up wins.
  assign sdaWire = !(sdaPull || sdaOe);

  // Register array answering the pointer at once, written on the strobe.
  always @(posedge clock) begin
    if (regWrStrobe) begin
      mem[regAddr] <= regWrData;
    end
  end

  led_serial_port #(.EXT_CLK_TIMEOUT(64)) i_dut (
    .clock(clock), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .slave_id_select_low(sel[0]), .slave_id_select_high(sel[1]),
    .external_slow_clock_in(slowClk), .thermalShutdown(thermal),
    .powerSaveActive(powerSave), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdData(mem[regAddr]), .regRdStrobe(regRdStrobe),
    .busBusy(busBusy), .startupHold(startupHold), .extClockPresent(extPresent),
    .oscillatorOff(oscOff));

  bus_master_model i_master (.sclOut(sclIn), .sdaPull(sdaPull), .sdaLine(sdaWire));

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Start plus address byte of id; returns the ninth-pulse line (0 = acknowledged).
  task automatic addr(input logic [1:0] id, input logic rd, output logic ack);
    logic [7:0] r;
    @(posedge clock) #2;
    i_master.startCond();
    i_master.byteX({5'h0c, id, rd}, 1'b1, r, ack);
  endtask

  // Pointer and data bytes, each expected acknowledged, then stop.
  task automatic wrBytes(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1,
                         input int n);
    logic [7:0] r;
    logic       a;
    i_master.byteX(ptr, 1'b1, r, a);
    check(a, 1'b0);
    i_master.byteX(d0, 1'b1, r, a);
    check(a, 1'b0);
    if (n > 1) begin
      i_master.byteX(d1, 1'b1, r, a);
      check(a, 1'b0);
    end
    i_master.stopCond();
  endtask

  // Every select code: a foreign id is refused, the own id is written.
  task automatic t_select();
    logic a;
    for (int s = 0; s < 4; s++) begin
      @(posedge clock) #2 sel = s[1:0];
      addr(sel ^ 2'h1, 1'b0, a);
      check(a, 1'b1);
      check(busBusy, 1'b1);
      i_master.stopCond();
      addr(sel, 1'b0, a);
      check(a, 1'b0);
      wrBytes(8'h20 + s[7:0], 8'hc0 + s[7:0], 8'h00, 1);
      check(mem[8'h20 + s[7:0]], 8'hc0 + s[7:0]);
    end
  endtask

  // Burst across the top of the pointer range wraps to zero.
  task automatic t_burst();
    logic a;
    addr(sel, 1'b0, a);
    wrBytes(8'hff, 8'ha5, 8'h3c, 2);
    check(mem[8'hff], 8'ha5);
    check(mem[8'h00], 8'h3c);
    check(regAddr, 8'h01);
  endtask

  // Pointer write, repeated start, two reads: acknowledged then refused.
  task automatic t_read();
    logic [7:0] r;
    logic       a;
    addr(sel, 1'b0, a);
    i_master.byteX(8'h02, 1'b1, r, a);
    addr(sel, 1'b1, a);
    check(a, 1'b0);
    i_master.byteX(8'hff, 1'b0, r, a);
    check(r, mem[8'h02]);
    i_master.byteX(8'hff, 1'b1, r, a);
    check(r, mem[8'h03]);
    i_master.stopCond();
    check(regAddr, 8'h03);
    check(busBusy, 1'b0);
  endtask

  // A stop in mid data byte drops the byte.
  task automatic t_abort();
    logic [7:0] r;
    logic       a;
    addr(sel, 1'b0, a);
    i_master.byteX(8'h50, 1'b1, r, a);
    for (int i = 0; i < 4; i++) begin
      i_master.bitX(1'b0, a);
    end
    i_master.stopCond();
    check(mem[8'h50], 8'h50 ^ 8'h5a);
    check(busBusy, 1'b0);
  endtask

  // Fault: no answer until it clears, then normal acknowledge.
  task automatic t_thermal();
    logic a;
    @(posedge clock) #2 thermal = 1'b1;
    repeat (6) @(posedge clock);
    check(startupHold, 1'b1);
    addr(sel, 1'b0, a);
    check(a, 1'b1);
    i_master.stopCond();
    @(posedge clock) #2 thermal = 1'b0;
    repeat (6) @(posedge clock);
    check(startupHold, 1'b0);
    addr(sel, 1'b0, a);
    check(a, 1'b0);
    i_master.stopCond();
  endtask

  // Slow clock present in power save stops the oscillator; a stuck clock does not.
  task automatic t_slow();
    @(posedge clock) #2 powerSave = 1'b1;
    repeat (16) begin
      repeat (10) @(posedge clock);
      #2 slowClk = ~slowClk;
    end
    check(extPresent, 1'b1);
    check(oscOff, 1'b1);
    repeat (100) @(posedge clock);
    check(extPresent, 1'b0);
    check(oscOff, 1'b0);
  endtask

  // A hang is cut short after far more cycles than the sequence needs.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 25000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
    repeat (10) @(posedge clock);
    #2 rst_n = 1'b1;
    repeat (6) @(posedge clock);
    check(regAddr, 8'h00);
    check(sdaOe, 1'b0);
    check(sdaOut, 1'b0);
    t_select();
    t_burst();
    t_read();
    t_abort();
    t_thermal();
    t_slow();
    close_out();
  end
endmodule
